// ==== scsp_defs.vh ====
/*
  Constants for the strap decoder and the SPI register-access port.
  Assumes it is included by bare name into each design file that needs it.
*/
`ifndef SCSP_DEFS_VH
`define SCSP_DEFS_VH

// SPI word layout.
`define SCSP_WORD_W 16
`define SCSP_ADDR_W 15
`define SCSP_BIT_FIRST 4'h0
`define SCSP_BIT_LAST 4'hF
`define SCSP_DIR_BIT 0
`define SCSP_DIR_WRITE 1'b1
`define SCSP_ADDR_ONE 15'h0001

// Process-data image windows in register space, in word addresses.
`define SCSP_PD_IN_BASE 15'h0100
`define SCSP_PD_OUT_BASE 15'h0200
`define SCSP_PD_OUT_END 15'h0210

// Strap codes on option_straps.
`define SCSP_OPT_ANA_SMALL 3'h0
`define SCSP_OPT_ANA_MID 3'h1
`define SCSP_OPT_ANA_LARGE 3'h2
`define SCSP_OPT_SR_SMALL 3'h3
`define SCSP_OPT_SR_MID 3'h4
`define SCSP_OPT_SR_LARGE 3'h5
`define SCSP_OPT_HOST_MODBUS 3'h0
`define SCSP_OPT_HOST_SPI 3'h1

// Process image sizes in bytes.
`define SCSP_BYTES_0 6'h00
`define SCSP_BYTES_4 6'h04
`define SCSP_BYTES_8 6'h08
`define SCSP_BYTES_12 6'h0C
`define SCSP_BYTES_28 6'h1C
`define SCSP_BYTES_32 6'h20
`define SCSP_SHIFT_AFTER_ANA 6'h04
`define SCSP_SHIFT_AT_ZERO 6'h00

// Cycles the pull-downs get to settle before the straps are latched.
`define SCSP_STRAP_SETTLE 4'h8
`define SCSP_CNT_ONE 4'h1

`endif

// ==== scsp_sync.v ====
/*
  Two-stage synchroniser for a group of asynchronous inputs.
  Assumes the inputs are quasi-static or slow compared with clk.
*/
`timescale 1ns/10ps
module scsp_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage;

  always @(posedge clk) begin
    if (!rst_n) begin
      stage <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      stage <= din;
      dout <= stage;
    end
  end

endmodule

// ==== scsp_strap_spi.v ====
/*
  Start-up strap decoder and host-mode SPI slave register-access port.
  Assumes a register file on ref_clk that answers a read one cycle after
  reg_rd_req, and an SPI master whose clock is far slower than ref_clk.
*/
`timescale 1ns/10ps
`include "scsp_defs.vh"
module scsp_strap_spi (
  input wire ref_clk,
  input wire rst_n,
  input wire mode_select_strap,
  input wire option_strap_0,
  input wire option_strap_1,
  input wire option_strap_2,
  output reg strap_pulldown_en,
  output reg strap_input_mode,
  output reg strap_valid,
  output reg mode_standalone,
  output reg mode_host_modbus,
  output reg mode_host_spi,
  output reg mode_reserved,
  output reg analog_bytes_en,
  output reg [5:0] process_in_bytes,
  output reg [5:0] process_out_bytes,
  output reg [5:0] shift_byte_first,
  input wire spi_sclk,
  input wire spi_ss_n,
  input wire spi_mosi,
  output reg spi_miso_out,
  output reg spi_miso_oe_n,
  output reg spi_abort,
  input wire io_cycle_tick,
  output reg cycle_sync_request,
  input wire [15:0] status_word,
  output reg [14:0] reg_addr,
  output reg reg_rd_req,
  input wire [15:0] reg_rd_data,
  output reg reg_wr_en,
  output reg [15:0] reg_wr_data
);

  // Strap handling.
  wire [3:0] strap_sync;
  reg [3:0] settle_cnt;
  wire [2:0] option_straps;

  scsp_sync #(
    .WIDTH(4)
  ) u_strap_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .din({mode_select_strap, option_strap_2, option_strap_1,
          option_strap_0}),
    .dout(strap_sync)
  );

  assign option_straps = strap_sync[2:0];

  // Pull-downs are on from reset, so the pins never float while sampled.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_pulldown_en <= 1'b1;
      strap_input_mode <= 1'b1;
      settle_cnt <= `SCSP_BIT_FIRST;
      strap_valid <= 1'b0;
    end else if (!strap_valid) begin
      if (settle_cnt == `SCSP_STRAP_SETTLE) begin
        strap_valid <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + `SCSP_CNT_ONE;
      end
    end
  end

  // The decode is taken once and held until the next reset.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_standalone <= 1'b0;
      mode_host_modbus <= 1'b0;
      mode_host_spi <= 1'b0;
      mode_reserved <= 1'b0;
      analog_bytes_en <= 1'b0;
      process_in_bytes <= `SCSP_BYTES_0;
      process_out_bytes <= `SCSP_BYTES_0;
      shift_byte_first <= `SCSP_SHIFT_AT_ZERO;
    end else if (!strap_valid && settle_cnt == `SCSP_STRAP_SETTLE) begin
      mode_standalone <= ~strap_sync[3];
      mode_host_modbus <= strap_sync[3] &&
                          option_straps == `SCSP_OPT_HOST_MODBUS;
      mode_host_spi <= strap_sync[3] &&
                       option_straps == `SCSP_OPT_HOST_SPI;
      mode_reserved <= 1'b0;
      analog_bytes_en <= 1'b0;
      process_in_bytes <= `SCSP_BYTES_0;
      process_out_bytes <= `SCSP_BYTES_0;
      shift_byte_first <= `SCSP_SHIFT_AT_ZERO;
      if (!strap_sync[3]) begin
        case (option_straps)
          `SCSP_OPT_ANA_SMALL: begin
            analog_bytes_en <= 1'b1;
            process_in_bytes <= `SCSP_BYTES_8;
            process_out_bytes <= `SCSP_BYTES_4;
            shift_byte_first <= `SCSP_SHIFT_AFTER_ANA;
          end
          `SCSP_OPT_ANA_MID: begin
            analog_bytes_en <= 1'b1;
            process_in_bytes <= `SCSP_BYTES_12;
            process_out_bytes <= `SCSP_BYTES_8;
            shift_byte_first <= `SCSP_SHIFT_AFTER_ANA;
          end
          `SCSP_OPT_ANA_LARGE: begin
            analog_bytes_en <= 1'b1;
            process_in_bytes <= `SCSP_BYTES_32;
            process_out_bytes <= `SCSP_BYTES_28;
            shift_byte_first <= `SCSP_SHIFT_AFTER_ANA;
          end
          `SCSP_OPT_SR_SMALL: begin
            process_in_bytes <= `SCSP_BYTES_4;
            process_out_bytes <= `SCSP_BYTES_4;
          end
          `SCSP_OPT_SR_MID: begin
            process_in_bytes <= `SCSP_BYTES_8;
            process_out_bytes <= `SCSP_BYTES_8;
          end
          `SCSP_OPT_SR_LARGE: begin
            process_in_bytes <= `SCSP_BYTES_32;
            process_out_bytes <= `SCSP_BYTES_32;
          end
          default: begin
            // Reserved codes leave the image empty and flag it.
            mode_reserved <= 1'b1;
          end
        endcase
      end else if (option_straps != `SCSP_OPT_HOST_MODBUS &&
                   option_straps != `SCSP_OPT_HOST_SPI) begin
        mode_reserved <= 1'b1;
      end
    end
  end

  // Cycle-sync request follows the IO-Link cycle tick in host mode.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cycle_sync_request <= 1'b0;
    end else begin
      cycle_sync_request <= io_cycle_tick &&
                            (mode_host_spi || mode_host_modbus);
    end
  end

  // SPI pins: synchronised, then edges found on ref_clk.
  wire [2:0] spi_sync;
  wire sclk_s;
  wire ss_n_s;
  wire mosi_s;
  reg sclk_d;
  reg ss_n_d;
  wire sclk_rise;
  wire sclk_fall;
  wire sel_fall;
  wire sel_rise;
  wire selected;

  scsp_sync #(
    .WIDTH(3)
  ) u_spi_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .din({spi_sclk, spi_ss_n, spi_mosi}),
    .dout(spi_sync)
  );

  assign sclk_s = spi_sync[2];
  assign ss_n_s = spi_sync[1];
  assign mosi_s = spi_sync[0];

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sclk_d <= 1'b1;
      ss_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      ss_n_d <= ss_n_s;
    end
  end

  assign selected = mode_host_spi && !ss_n_s;
  assign sclk_rise = selected && sclk_s && !sclk_d;
  assign sclk_fall = selected && !sclk_s && sclk_d;
  assign sel_fall = mode_host_spi && !ss_n_s && ss_n_d;
  assign sel_rise = mode_host_spi && ss_n_s && !ss_n_d;

  // Transaction state.
  reg [15:0] rx_shift;
  reg [15:0] tx_shift;
  reg [15:0] tx_word;
  reg [3:0] bit_cnt;
  reg addr_phase;
  reg wr_dir;
  reg [14:0] cur_addr;
  reg word_done;
  reg rd_pending;
  wire [15:0] rx_word;
  wire [14:0] rx_addr;
  wire rx_wr;
  wire [14:0] next_addr;
  reg [14:0] next_fetch;

  assign rx_word = rx_shift;
  assign rx_addr = rx_shift[`SCSP_WORD_W-1:1];
  assign rx_wr = rx_shift[`SCSP_DIR_BIT] == `SCSP_DIR_WRITE;
  assign next_addr = cur_addr + `SCSP_ADDR_ONE;

  // A write to the output image fetches the matching input image word.
  always @* begin
    next_fetch = addr_phase ? rx_addr : next_addr;
    if ((addr_phase ? rx_wr : wr_dir) &&
        next_fetch >= `SCSP_PD_OUT_BASE &&
        next_fetch < `SCSP_PD_OUT_END) begin
      next_fetch = next_fetch - `SCSP_PD_OUT_BASE +
                   `SCSP_PD_IN_BASE;
    end
  end

  // Receive side: sample on rising edges, count 16 bits per word.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_shift <= 16'h0000;
      bit_cnt <= `SCSP_BIT_FIRST;
      word_done <= 1'b0;
      spi_abort <= 1'b0;
    end else begin
      word_done <= 1'b0;
      spi_abort <= 1'b0;
      if (sel_fall || sel_rise) begin
        // Any partial word is dropped at a select edge.
        spi_abort <= sel_rise && bit_cnt != `SCSP_BIT_FIRST;
        bit_cnt <= `SCSP_BIT_FIRST;
      end else if (sclk_rise) begin
        rx_shift <= {rx_shift[14:0], mosi_s};
        bit_cnt <= bit_cnt + `SCSP_CNT_ONE;
        word_done <= bit_cnt == `SCSP_BIT_LAST;
      end
    end
  end

  // Word handling: address word, then data words with auto-increment.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_phase <= 1'b1;
      wr_dir <= 1'b0;
      cur_addr <= 15'h0000;
      reg_addr <= 15'h0000;
      reg_rd_req <= 1'b0;
      reg_wr_en <= 1'b0;
      reg_wr_data <= 16'h0000;
      rd_pending <= 1'b0;
      tx_word <= 16'h0000;
    end else begin
      reg_rd_req <= 1'b0;
      reg_wr_en <= 1'b0;
      rd_pending <= reg_rd_req;
      if (rd_pending) begin
        tx_word <= reg_rd_data;
      end
      if (sel_fall) begin
        addr_phase <= 1'b1;
        tx_word <= status_word;
      end else if (sel_rise) begin
        addr_phase <= 1'b1;
      end else if (word_done && selected) begin
        addr_phase <= 1'b0;
        reg_addr <= next_fetch;
        reg_rd_req <= 1'b1;
        if (addr_phase) begin
          cur_addr <= rx_addr;
          wr_dir <= rx_wr;
        end else begin
          cur_addr <= next_addr;
          if (wr_dir) begin
            // Old value, or the input image word for an output-window address, already went out on this word.
            reg_wr_en <= 1'b1;
            reg_wr_data <= rx_word;
          end
          // Read direction leaves the register file alone.
        end
      end
    end
  end

  // Transmit side: change data on falling edges, MSB first.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_shift <= 16'h0000;
      spi_miso_out <= 1'b1;
      spi_miso_oe_n <= 1'b1;
    end else begin
      spi_miso_oe_n <= !selected;
      if (sclk_fall) begin
        if (bit_cnt == `SCSP_BIT_FIRST) begin
          tx_shift <= tx_word;
          spi_miso_out <= tx_word[`SCSP_WORD_W-1];
        end else begin
          tx_shift <= {tx_shift[14:0], 1'b0};
          spi_miso_out <= tx_shift[`SCSP_WORD_W-2];
        end
      end
    end
  end

endmodule

// ==== scsp_host_model.sv ====
/*
  Behavioural host that masters the SPI port of the strap and SPI block.
  Assumes it is the only master on the bus and that time runs in ns.
*/
`timescale 1ns/10ps
module scsp_host_model (
  output logic spi_sclk,
  output logic spi_ss_n,
  output logic spi_mosi,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe_n
);
  // A released line shows the inverse of its last level.
  wire miso = spi_miso_oe_n ? ~spi_miso_out : spi_miso_out;
  initial begin
    spi_sclk = 1'b1;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b1;
  end
  task automatic word(input logic [15:0] tx, input int nb,
      output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 15; i > 15 - nb; i--) begin
      spi_sclk = 1'b0;
      spi_mosi = tx[i];
      #160;
      spi_sclk = 1'b1;
      #150;
      rx[i] = miso;
      #10;
    end
  endtask
  task automatic xact(input logic [14:0] addr, input logic wr, input int n,
      input logic [63:0] tx, output logic [15:0] st, output logic [63:0] rx);
    logic [15:0] w;
    rx = 64'h0;
    spi_ss_n = 1'b0;
    #3000;
    word({addr, wr}, 16, st);
    #24000;
    for (int k = 0; k < n; k++) begin
      word(tx[k*16 +: 16], 16, w);
      rx[k*16 +: 16] = w;
      #3000;
    end
    spi_ss_n = 1'b1;
    #4600;
  endtask
  task automatic abort_half();
    logic [15:0] junk;
    spi_ss_n = 1'b0;
    #3000;
    word(16'hFFFF, 8, junk);
    #3000;
    spi_ss_n = 1'b1;
    #4600;
  endtask
endmodule

// ==== scsp_props.sv ====
/*
  Concurrent checks on the strap decoder and SPI port.
  Assumes one ref_clk domain with a synchronous active-low reset.
*/
`timescale 1ns/10ps
module scsp_props (
  input wire ref_clk,
  input wire rst_n,
  input wire strap_pulldown_en,
  input wire strap_input_mode,
  input wire strap_valid,
  input wire mode_standalone,
  input wire mode_host_modbus,
  input wire mode_host_spi,
  input wire mode_reserved,
  input wire spi_ss_n,
  input wire spi_miso_oe_n,
  input wire spi_abort,
  input wire io_cycle_tick,
  input wire cycle_sync_request,
  input wire reg_rd_req,
  input wire reg_wr_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire host = mode_host_spi | mode_host_modbus;
  wire [3:0] modes = {mode_standalone, mode_host_modbus, mode_host_spi,
    mode_reserved};
  sequence s_tick_in_host;
    io_cycle_tick && host;
  endsequence
  sequence s_no_write;
    !reg_wr_en [*4];
  endsequence
  chk_pulls_first:
    assert property (!strap_valid |-> strap_pulldown_en && strap_input_mode)
      else $error("straps sampled without pull-downs");
  chk_one_mode:
    assert property (strap_valid |-> $onehot({mode_standalone,
      mode_host_modbus, mode_host_spi, mode_reserved & ~mode_standalone}))
      else $error("mode outputs not one-hot");
  chk_mode_frozen:
    assert property (strap_valid && $past(strap_valid) |-> $stable(modes))
      else $error("mode changed after latch");
  chk_sync_tick:
    assert property (s_tick_in_host |=> cycle_sync_request)
      else $error("tick without sync request");
  chk_sync_host_only:
    assert property (cycle_sync_request |-> host)
      else $error("sync request outside host mode");
  chk_idle_release:
    assert property (spi_ss_n [*4] |-> spi_miso_oe_n)
      else $error("miso driven while deselected");
  chk_spi_only:
    assert property (!mode_host_spi |-> spi_miso_oe_n)
      else $error("miso driven outside spi mode");
  chk_abort_quiet:
    assert property (spi_abort |-> s_no_write)
      else $error("write after aborted word");
  chk_write_fetch:
    assert property (reg_wr_en |-> reg_rd_req && mode_host_spi)
      else $error("write without paired fetch");
endmodule
bind scsp_strap_spi scsp_props chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .strap_pulldown_en(strap_pulldown_en),
  .strap_input_mode(strap_input_mode), .strap_valid(strap_valid),
  .mode_standalone(mode_standalone), .mode_host_modbus(mode_host_modbus),
  .mode_host_spi(mode_host_spi), .mode_reserved(mode_reserved),
  .spi_ss_n(spi_ss_n), .spi_miso_oe_n(spi_miso_oe_n),
  .spi_abort(spi_abort), .io_cycle_tick(io_cycle_tick),
  .cycle_sync_request(cycle_sync_request), .reg_rd_req(reg_rd_req),
  .reg_wr_en(reg_wr_en));

// ==== tb.sv ====
/*
  Self-checking bench for the strap decoder and SPI register-access port.
  Assumes the host model and the checker are compiled before it.
*/
`timescale 1ns/10ps
module tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] straps = 4'h0;
  logic io_cycle_tick = 1'b0;
  logic [15:0] status_word = 16'h5A3C;
  logic [15:0] reg_rd_data = 16'h0000;
  logic [15:0] mem [0:1023];
  logic [14:0] wa = 15'h0000;
  int wcnt = 0;
  int cyc = 0;
  int bad_count = 0;
  int total_checks = 0;
  int abort_cnt = 0;
  wire spi_sclk, spi_ss_n, spi_mosi, spi_miso_out, spi_miso_oe_n;
  wire strap_valid, mode_standalone, mode_host_modbus, mode_host_spi;
  wire mode_reserved, analog_bytes_en, reg_rd_req, reg_wr_en;
  wire cycle_sync_request, spi_abort;
  wire [5:0] process_in_bytes, process_out_bytes, shift_byte_first;
  wire [14:0] reg_addr;
  wire [15:0] reg_wr_data;
  always #20 ref_clk = ~ref_clk;
  scsp_strap_spi dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .mode_select_strap(straps[3]), .option_strap_0(straps[0]),
    .option_strap_1(straps[1]), .option_strap_2(straps[2]),
    .strap_pulldown_en(), .strap_input_mode(), .strap_valid(strap_valid),
    .mode_standalone(mode_standalone), .mode_host_modbus(mode_host_modbus),
    .mode_host_spi(mode_host_spi), .mode_reserved(mode_reserved),
    .analog_bytes_en(analog_bytes_en), .process_in_bytes(process_in_bytes),
    .process_out_bytes(process_out_bytes),
    .shift_byte_first(shift_byte_first), .spi_sclk(spi_sclk),
    .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso_out(spi_miso_out),
    .spi_miso_oe_n(spi_miso_oe_n), .spi_abort(spi_abort),
    .io_cycle_tick(io_cycle_tick), .cycle_sync_request(cycle_sync_request),
    .status_word(status_word), .reg_addr(reg_addr),
    .reg_rd_req(reg_rd_req), .reg_rd_data(reg_rd_data),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data));
  scsp_host_model host (.spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n),
    .spi_mosi(spi_mosi), .spi_miso_out(spi_miso_out),
    .spi_miso_oe_n(spi_miso_oe_n));
  function automatic logic [15:0] pre(input logic [15:0] a);
    return a ^ 16'hC3C3;
  endfunction
  initial for (int i = 0; i < 1024; i++) mem[i] = pre(16'(i));
  // Register file answering one cycle after a fetch, plus timeout.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    io_cycle_tick <= #2 (cyc % 50 == 0);
    if (reg_rd_req) reg_rd_data <= #2 mem[reg_addr[9:0]];
    if (spi_abort) abort_cnt <= abort_cnt + 1;
    if (reg_wr_en) begin
      mem[wa[9:0]] <= reg_wr_data;
      wa <= wa + 15'h0001;
      wcnt <= wcnt + 1;
    end
    if (cyc == 15000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic reset_to(input logic [3:0] code);
    tick(1);
    straps = code;
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    for (int i = 0; i < 40 && strap_valid !== 1'b1; i++) tick(1);
    check(strap_valid, 1'b1);
  endtask
  task automatic t_straps();
    logic [3:0] m;
    logic [18:0] szt [0:5];
    szt = '{19'h4_8104, 19'h4_C204, 19'h6_0704, 19'h0_4100, 19'h0_8200,
      19'h2_0800};
    for (int c = 0; c < 16; c++) begin
      m = c[3] ? (c[2:0] == 3'h0 ? 4'h4 : c[2:0] == 3'h1 ? 4'h2 : 4'h1)
        : (c[2:1] == 2'h3 ? 4'h9 : 4'h8);
      reset_to(4'(c));
      check({mode_standalone, mode_host_modbus, mode_host_spi,
        mode_reserved}, m);
      if (m == 4'h8) check({analog_bytes_en, process_in_bytes,
        process_out_bytes, shift_byte_first}, szt[c[2:0]]);
    end
    reset_to(4'h9);
    straps = 4'h0;
    tick(20);
    check(mode_host_spi, 1'b1);
    $display("done straps");
  endtask
  task automatic t_rw();
    logic [15:0] st;
    logic [63:0] rx;
    wa = 15'h0010;
    host.xact(15'h0010, 1'b1, 2, 64'h0000_0000_BEEF_1234, st, rx);
    check(st, 16'h5A3C);
    check(rx[31:0], {pre(16'h0011), pre(16'h0010)});
    check({mem[16], mem[17]}, 32'h1234_BEEF);
    check(wcnt, 2);
    host.xact(15'h0010, 1'b0, 3, 64'hFFFF_FFFF_FFFF_FFFF, st, rx);
    check(rx[47:0], {pre(16'h0012), 32'hBEEF_1234});
    check({mem[16], mem[18]}, {16'h1234, pre(16'h0012)});
    check(wcnt, 2);
    check(abort_cnt, 0);
    $display("done read write");
  endtask
  task automatic t_image();
    logic [15:0] st;
    logic [63:0] rx;
    wa = 15'h0200;
    host.xact(15'h0200, 1'b1, 1, 64'h7777, st, rx);
    check(rx[15:0], pre(16'h0100));
    check(mem[512], 16'h7777);
    $display("done image");
  endtask
  task automatic t_abort();
    logic [15:0] st;
    logic [63:0] rx;
    host.abort_half();
    check(wcnt, 3);
    check(abort_cnt, 1);
    check(spi_miso_oe_n, 1'b1);
    host.xact(15'h0010, 1'b0, 1, 64'h0, st, rx);
    check(rx[15:0], 16'h1234);
    $display("done abort");
  endtask
  task automatic t_sync();
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 60 && !seen; i++) begin
      tick(1);
      seen = cycle_sync_request === 1'b1;
    end
    check(seen, 1'b1);
    $display("done sync");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    t_straps();
    t_rw();
    t_image();
    t_abort();
    t_sync();
    tally_and_finish();
  end
endmodule
